// >>> design/fcc_pkg.sv
// Purpose: constants and types for the far-end alarm code controller
// Assumes: 32-bit apb, registers addressed by index times four
// Notes: one port of the framer
`default_nettype none
package fcc_pkg;
	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_TX_CTRL = 8'hc0;
	localparam logic [7:0] IDX_TX_VAL = 8'hc2;
	localparam logic [7:0] IDX_TX_STAT = 8'hc4;
	localparam logic [7:0] IDX_TX_LAT = 8'hc6;
	localparam logic [7:0] IDX_TX_IE = 8'hc8;
	localparam logic [7:0] IDX_RX_CTRL = 8'hd0;
	localparam logic [7:0] IDX_RX_STAT = 8'hd4;
	localparam logic [7:0] IDX_RX_LAT = 8'hd6;
	localparam logic [7:0] IDX_RX_IE = 8'hd8;
	localparam logic [7:0] IDX_RX_FIFO = 8'hdc;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CODE_W = 6;
	localparam int TX_MODE_LSB = 0;
	localparam int TX_LOAD_BIT = 2;
	localparam int CODE_A_LSB = 0;
	localparam int CODE_B_LSB = 8;
	localparam int TX_IDLE_BIT = 0;
	localparam int RX_RESET_BIT = 0;
	localparam int RX_IDLE_BIT = 0;
	localparam int RX_DET_BIT = 1;
	localparam int RX_OVF_BIT = 2;
	localparam int RX_EMPTY_BIT = 3;
	localparam int RX_INVALID_BIT = 7;
	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic [15:0] CTRL_RSVD_RD = 16'h0800;
	localparam logic TX_IDLE_LAT_RST = 1'b1;
	localparam logic [2:0] RX_LAT_RST = 3'h1;
	localparam logic [3:0] FRAME_LAST = 4'hf;
	localparam logic [3:0] REPEAT_LAST = 4'h9;
	localparam logic [4:0] GAP_MAX = 5'h1f;
	localparam logic [4:0] GAP_FRAME = 5'h0f;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_AW = 2;
	// ************************************************************
	// modes and states
	// ************************************************************
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_DUAL = 2'h2;
	localparam logic [1:0] MODE_CONT = 2'h3;
	typedef enum logic [1:0] {
		TX_ST_IDLE,
		TX_ST_CODE_A,
		TX_ST_CODE_B,
		TX_ST_CONT
	} fcc_tx_state_t;
endpackage
`default_nettype wire

// >>> design/fcc_feac_ctrl.sv
// Purpose: far-end alarm code controller, transmit and receive
// Assumes: apb3 slave, line bit strobes from the framer on clk_in
// Notes: zero wait state apb, fifo of four codes
// Function
// - load bit rising edge captures mode, codes
// - load aborts current sending, restarts fresh
// - mode 00 sends only all ones
// - mode 01 sends A ten times
// - mode 10 sends A, B ten each
// - mode 11 repeats A until reload
// - code bit 0 sent first; A/B fields
// - tx idle status reflects all-ones output
// - tx idle latched on rise, set at reset
// - interrupt needs enable and port enable
// - rx reset flushes fifo, discards input
// - fifo empty status reads one when empty
// - detect status high while codeword received
// - rx idle status high on all ones
// - overflow latched when fifo full; code lost
// - detect latched on detect status rise
// - rx idle latched on rise, set at reset
// - bit 7 flags invalid data when empty
// - received code bit 0 is first bit
// - reading low byte advances the fifo
`timescale 1ns/1ns
`default_nettype none
module fcc_feac_ctrl (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [fcc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic port_status_irq_enable_in,
	input wire logic tx_bit_en_in,
	output logic tx_line_bit_out,
	input wire logic rx_bit_en_in,
	input wire logic rx_line_bit_in,
	output logic irq_out
);
	import fcc_pkg::*;
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == {2'h0, idx});
	endfunction
	function automatic logic [15:0] frame_of(input logic [5:0] c);
		return {8'hff, 1'b0, c, 1'b0};
	endfunction
	// ************************************************************
	// apb decode
	// ************************************************************
	logic [31:0] rdata_nxt;
	wire setup = psel_in & ~penable_in & ~pready_out;
	wire access = psel_in & penable_in & pready_out;
	wire wr = access & pwrite_in;
	wire rd = access & ~pwrite_in;
	wire h_tx_ctrl = hit(paddr_in, IDX_TX_CTRL);
	wire h_tx_val = hit(paddr_in, IDX_TX_VAL);
	wire h_tx_stat = hit(paddr_in, IDX_TX_STAT);
	wire h_tx_lat = hit(paddr_in, IDX_TX_LAT);
	wire h_tx_ie = hit(paddr_in, IDX_TX_IE);
	wire h_rx_ctrl = hit(paddr_in, IDX_RX_CTRL);
	wire h_rx_stat = hit(paddr_in, IDX_RX_STAT);
	wire h_rx_lat = hit(paddr_in, IDX_RX_LAT);
	wire h_rx_ie = hit(paddr_in, IDX_RX_IE);
	wire h_rx_fifo = hit(paddr_in, IDX_RX_FIFO);
	wire mapped = h_tx_ctrl | h_tx_val | h_tx_stat | h_tx_lat | h_tx_ie |
		h_rx_ctrl | h_rx_stat | h_rx_lat | h_rx_ie | h_rx_fifo;
	wire [15:0] wd = pwdata_in[15:0];
	// ************************************************************
	// registers
	// ************************************************************
	logic [1:0] tx_code_mode_r;
	logic tx_codeword_load_r;
	logic [5:0] tx_code_a_r;
	logic [5:0] tx_code_b_r;
	logic tx_idle_latched_r;
	logic tx_idle_irq_en_r;
	logic rx_code_reset_r;
	logic [2:0] rx_lat_r;
	logic [2:0] rx_ie_r;
	// ************************************************************
	// transmit processor
	// ************************************************************
	fcc_tx_state_t tx_st_r, tx_st_nxt;
	logic [1:0] tx_act_mode_r;
	logic [5:0] tx_act_a_r;
	logic [5:0] tx_act_b_r;
	logic [3:0] tx_idx_r, tx_idx_nxt;
	logic [3:0] tx_rep_r, tx_rep_nxt;
	logic tx_idle_prev_r;
	wire [1:0] wr_mode = wd[TX_MODE_LSB +: 2];
	wire tx_load = wr & h_tx_ctrl & wd[TX_LOAD_BIT] &
		~tx_codeword_load_r;
	wire [5:0] tx_cur_code = (tx_st_r == TX_ST_CODE_B) ? tx_act_b_r :
		tx_act_a_r;
	wire [15:0] tx_frame = frame_of(tx_cur_code);
	wire tx_idle_status = (tx_st_r == TX_ST_IDLE);
	wire tx_bit_nxt = tx_idle_status | tx_frame[tx_idx_r];
	wire tx_frame_end = tx_bit_en_in & (tx_idx_r == FRAME_LAST);
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_idx_nxt = tx_idx_r;
		tx_rep_nxt = tx_rep_r;
		if (tx_load) begin
			tx_idx_nxt = 4'h0;
			tx_rep_nxt = 4'h0;
			case (wr_mode)
				MODE_IDLE: tx_st_nxt = TX_ST_IDLE;
				MODE_SINGLE: tx_st_nxt = TX_ST_CODE_A;
				MODE_DUAL: tx_st_nxt = TX_ST_CODE_A;
				MODE_CONT: tx_st_nxt = TX_ST_CONT;
				default: tx_st_nxt = TX_ST_IDLE;
			endcase
		end else if (tx_bit_en_in && !tx_idle_status) begin
			tx_idx_nxt = tx_idx_r + 4'h1;
		end
		if (!tx_load && tx_frame_end) begin
			case (tx_st_r)
				TX_ST_CODE_A: begin
					tx_rep_nxt = tx_rep_r + 4'h1;
					if (tx_rep_r == REPEAT_LAST) begin
						tx_rep_nxt = 4'h0;
						if (tx_act_mode_r == MODE_DUAL) begin
							tx_st_nxt = TX_ST_CODE_B;
						end else begin
							tx_st_nxt = TX_ST_IDLE;
						end
					end
				end
				TX_ST_CODE_B: begin
					tx_rep_nxt = tx_rep_r + 4'h1;
					if (tx_rep_r == REPEAT_LAST) begin
						tx_rep_nxt = 4'h0;
						tx_st_nxt = TX_ST_IDLE;
					end
				end
				TX_ST_CONT: tx_st_nxt = TX_ST_CONT;
				default: tx_st_nxt = tx_st_r;
			endcase
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_st_r <= TX_ST_IDLE;
			tx_idx_r <= 4'h0;
			tx_rep_r <= 4'h0;
			tx_act_mode_r <= MODE_IDLE;
			tx_act_a_r <= 6'h0;
			tx_act_b_r <= 6'h0;
			tx_line_bit_out <= 1'b1;
			tx_idle_prev_r <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_idx_r <= tx_idx_nxt;
			tx_rep_r <= tx_rep_nxt;
			tx_idle_prev_r <= tx_idle_status;
			if (tx_load) begin
				tx_act_mode_r <= wr_mode;
				tx_act_a_r <= tx_code_a_r;
				tx_act_b_r <= tx_code_b_r;
			end
			if (tx_bit_en_in) begin
				tx_line_bit_out <= tx_bit_nxt;
			end
		end
	end
	// ************************************************************
	// receive detector
	// ************************************************************
	logic [15:0] rx_sr_r;
	logic rx_new_r;
	logic [4:0] rx_gap_r;
	logic [5:0] rx_last_r;
	logic rx_det_r;
	logic rx_idle_r;
	logic rx_det_nxt;
	wire [5:0] rx_code = rx_sr_r[6:1];
	wire rx_match = (rx_sr_r == frame_of(rx_code));
	wire rx_run = ~rx_code_reset_r;
	always_comb begin
		rx_det_nxt = rx_det_r;
		if (rx_new_r) begin
			if (rx_match) begin
				rx_det_nxt = (rx_gap_r == GAP_FRAME) &&
					(rx_code == rx_last_r);
			end else if (rx_gap_r >= GAP_FRAME) begin
				rx_det_nxt = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in || !rx_run) begin
			rx_sr_r <= 16'h0;
			rx_new_r <= 1'b0;
			rx_gap_r <= GAP_MAX;
			rx_last_r <= 6'h0;
			rx_det_r <= 1'b0;
			rx_idle_r <= 1'b0;
		end else begin
			rx_new_r <= rx_bit_en_in;
			if (rx_bit_en_in) begin
				rx_sr_r <= {rx_line_bit_in, rx_sr_r[15:1]};
			end
			rx_det_r <= rx_det_nxt;
			if (rx_new_r) begin
				rx_idle_r <= (rx_sr_r == 16'hffff);
				if (rx_match) begin
					rx_gap_r <= 5'h0;
					rx_last_r <= rx_code;
				end else if (rx_gap_r != GAP_MAX) begin
					rx_gap_r <= rx_gap_r + 5'h1;
				end
			end
		end
	end
	// ************************************************************
	// receive fifo
	// ************************************************************
	logic [5:0] fifo_mem_r [FIFO_DEPTH];
	logic [FIFO_AW-1:0] fifo_wp_r;
	logic [FIFO_AW-1:0] fifo_rp_r;
	logic [FIFO_AW:0] fifo_cnt_r;
	wire fifo_empty = (fifo_cnt_r == '0);
	wire fifo_full = (fifo_cnt_r == FIFO_DEPTH[FIFO_AW:0]);
	wire rx_push = rx_run & rx_det_nxt & ~rx_det_r;
	wire rx_pop = rd & h_rx_fifo & ~fifo_empty;
	wire rx_ovf = rx_push & fifo_full;
	wire rx_wr = rx_push & ~fifo_full;
	wire [5:0] fifo_head = fifo_empty ? 6'h0 : fifo_mem_r[fifo_rp_r];
	for (genvar gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifo
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				fifo_mem_r[gi] <= 6'h0;
			end else if (rx_wr && fifo_wp_r == FIFO_AW'(gi)) begin
				fifo_mem_r[gi] <= rx_last_r;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in || !rx_run) begin
			fifo_wp_r <= '0;
			fifo_rp_r <= '0;
			fifo_cnt_r <= '0;
		end else begin
			if (rx_wr) begin
				fifo_wp_r <= fifo_wp_r + 1'b1;
			end
			if (rx_pop) begin
				fifo_rp_r <= fifo_rp_r + 1'b1;
			end
			fifo_cnt_r <= fifo_cnt_r + {2'h0, rx_wr} - {2'h0, rx_pop};
		end
	end
	// ************************************************************
	// control, latched and enable registers
	// ************************************************************
	logic rx_idle_prev_r;
	wire [2:0] rx_set = {rx_ovf, rx_push,
		rx_run & rx_idle_r & ~rx_idle_prev_r};
	wire tx_set = tx_idle_status & ~tx_idle_prev_r;
	wire tx_clr = wr & h_tx_lat & wd[TX_IDLE_BIT];
	wire [2:0] rx_clr = {3{wr & h_rx_lat}} & wd[2:0];
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_code_mode_r <= MODE_IDLE;
			tx_codeword_load_r <= 1'b0;
			tx_code_a_r <= 6'h0;
			tx_code_b_r <= 6'h0;
			tx_idle_latched_r <= TX_IDLE_LAT_RST;
			tx_idle_irq_en_r <= 1'b0;
			rx_code_reset_r <= 1'b0;
			rx_lat_r <= RX_LAT_RST;
			rx_ie_r <= 3'h0;
			rx_idle_prev_r <= 1'b0;
		end else begin
			rx_idle_prev_r <= rx_idle_r;
			if (wr && h_tx_ctrl) begin
				tx_code_mode_r <= wr_mode;
				tx_codeword_load_r <= wd[TX_LOAD_BIT];
			end
			if (wr && h_tx_val) begin
				tx_code_a_r <= wd[CODE_A_LSB +: CODE_W];
				tx_code_b_r <= wd[CODE_B_LSB +: CODE_W];
			end
			if (wr && h_tx_ie) begin
				tx_idle_irq_en_r <= wd[TX_IDLE_BIT];
			end
			if (wr && h_rx_ctrl) begin
				rx_code_reset_r <= wd[RX_RESET_BIT];
			end
			if (wr && h_rx_ie) begin
				rx_ie_r <= wd[2:0];
			end
			tx_idle_latched_r <= (tx_idle_latched_r & ~tx_clr) |
				tx_set;
			rx_lat_r <= (rx_lat_r & ~rx_clr) | rx_set;
		end
	end
	// ************************************************************
	// read mux and apb answer
	// ************************************************************
	always_comb begin
		rdata_nxt = 32'h0;
		if (h_tx_ctrl) begin
			rdata_nxt[15:0] = CTRL_RSVD_RD;
			rdata_nxt[TX_LOAD_BIT] = tx_codeword_load_r;
			rdata_nxt[TX_MODE_LSB +: 2] = tx_code_mode_r;
		end
		if (h_tx_val) begin
			rdata_nxt[CODE_A_LSB +: CODE_W] = tx_code_a_r;
			rdata_nxt[CODE_B_LSB +: CODE_W] = tx_code_b_r;
		end
		if (h_tx_stat) begin
			rdata_nxt[TX_IDLE_BIT] = tx_idle_status;
		end
		if (h_tx_lat) begin
			rdata_nxt[TX_IDLE_BIT] = tx_idle_latched_r;
		end
		if (h_tx_ie) begin
			rdata_nxt[TX_IDLE_BIT] = tx_idle_irq_en_r;
		end
		if (h_rx_ctrl) begin
			rdata_nxt[15:0] = CTRL_RSVD_RD;
			rdata_nxt[RX_RESET_BIT] = rx_code_reset_r;
		end
		if (h_rx_stat) begin
			rdata_nxt[RX_EMPTY_BIT] = fifo_empty;
			rdata_nxt[RX_DET_BIT] = rx_det_r;
			rdata_nxt[RX_IDLE_BIT] = rx_idle_r;
		end
		if (h_rx_lat) begin
			rdata_nxt[2:0] = rx_lat_r;
		end
		if (h_rx_ie) begin
			rdata_nxt[2:0] = rx_ie_r;
		end
		if (h_rx_fifo) begin
			rdata_nxt[RX_INVALID_BIT] = fifo_empty;
			rdata_nxt[5:0] = fifo_head;
		end
	end
	wire irq_nxt = port_status_irq_enable_in &
		((tx_idle_latched_r & tx_idle_irq_en_r) |
		(|(rx_lat_r & rx_ie_r)));
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0;
			irq_out <= 1'b0;
		end else begin
			pready_out <= setup;
			pslverr_out <= setup & ~mapped;
			prdata_out <= (setup && !pwrite_in) ? rdata_nxt : 32'h0;
			irq_out <= irq_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> dv/fcc_assertions.sv
// Purpose: port properties of the alarm code controller
// Assumes: sees only the controller ports
// Notes: bound to every controller instance
`timescale 1ns/1ns
`default_nettype none
module fcc_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [fcc_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic port_status_irq_enable_in,
	input wire logic tx_bit_en_in,
	input wire logic tx_line_bit_out,
	input wire logic rx_bit_en_in,
	input wire logic rx_line_bit_in,
	input wire logic irq_out
);
	import fcc_pkg::*;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	a_ready_next: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready after setup");
	a_ready_only: assert property (pready_out |-> psel_in && penable_in)
		else $error("ready outside access");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data outside access");
	a_upper_zero: assert property (pready_out |-> prdata_out[31:16] == 16'h0)
		else $error("upper read bits set");
	a_line_hold: assert property (
		!$past(tx_bit_en_in) |-> $stable(tx_line_bit_out))
		else $error("line bit moved without strobe");
	a_irq_port: assert property (
		!port_status_irq_enable_in ##1 !port_status_irq_enable_in
		|-> !irq_out)
		else $error("irq without port enable");
endmodule
bind fcc_feac_ctrl fcc_checker chk_u (
	.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out),
	.port_status_irq_enable_in(port_status_irq_enable_in),
	.tx_bit_en_in(tx_bit_en_in), .tx_line_bit_out(tx_line_bit_out),
	.rx_bit_en_in(rx_bit_en_in), .rx_line_bit_in(rx_line_bit_in),
	.irq_out(irq_out)
);
`default_nettype wire

// >>> dv/fcc_far_end.sv
// Purpose: far terminal, loops the transmit line back
// Assumes: one bit time is four clocks
// Notes: last16_out holds the last sixteen bits, first in bit 0
`timescale 1ns/1ns
`default_nettype none
module fcc_far_end (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tx_line_bit_in,
	output logic tx_bit_en_out,
	output logic rx_bit_en_out,
	output logic rx_line_bit_out,
	output logic [15:0] last16_out
);
	logic [1:0] phase_r;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			phase_r <= 2'h0;
			last16_out <= 16'hffff;
		end else begin
			phase_r <= phase_r + 2'h1;
			if (rx_bit_en_out)
				last16_out <= {tx_line_bit_in, last16_out[15:1]};
		end
	end
	assign tx_bit_en_out = !rst_in && phase_r == 2'h0;
	assign rx_bit_en_out = !rst_in && phase_r == 2'h3;
	// line is only valid at the strobe
	assign rx_line_bit_out = rx_bit_en_out ? tx_line_bit_in : !tx_line_bit_in;
endmodule
`default_nettype wire

// >>> dv/fcc_feac_ctrl_tb_top.sv
// Purpose: bench for the alarm code controller
// Assumes: far end loops the line back
// Notes: reads checked against a queue
`timescale 1ns/1ns
`default_nettype none
module fcc_feac_ctrl_tb_top;
	import fcc_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel, penable, pwrite, port_en, pready_out, pslverr_out;
	logic tx_en, rx_en, tx_bit, rx_bit, irq_out;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_out;
	logic [15:0] last16, m_v;
	logic [32:0] exp_v, got_v, eq[$];
	logic [15:0] mq[$];
	logic [31:0] seed = 32'h0000004e;
	logic [5:0] c[5];
	logic [5:0] x, y, z;
	int n_mismatch = 0;
	int n_checks = 0;
	always #20 clk_in = !clk_in;
	fcc_feac_ctrl dut_u (
		.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.port_status_irq_enable_in(port_en), .tx_bit_en_in(tx_en),
		.tx_line_bit_out(tx_bit), .rx_bit_en_in(rx_en),
		.rx_line_bit_in(rx_bit), .irq_out(irq_out)
	);
	fcc_far_end far_u (
		.clk_in(clk_in), .rst_in(rst_in), .tx_line_bit_in(tx_bit),
		.tx_bit_en_out(tx_en), .rx_bit_en_out(rx_en),
		.rx_line_bit_out(rx_bit), .last16_out(last16)
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic stop_test();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ix,
		input logic [15:0] d, input logic [32:0] e, input logic [15:0] m);
		int n;
		n = 0;
		@(posedge clk_in);
		if (!w) begin
			eq.push_back(e);
			mq.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, ix, 2'h0};
		pwdata <= {16'h0, d};
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ix, input logic [15:0] v,
		input logic [15:0] m);
		apb(1'b0, ix, 16'h0, {1'b0, 16'h0, v}, m);
	endtask
	task automatic wr(input logic [7:0] ix, input logic [15:0] d);
		apb(1'b1, ix, d, 33'h0, 16'h0);
	endtask
	task automatic pulse(input logic r);
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while ((r ? rx_en : tx_en) !== 1'b1 && n < 9);
		if (n >= 9) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic frame(input logic [5:0] a);
		pulse(1'b0);
		repeat (16) pulse(1'b1);
		@(posedge clk_in);
		chk(last16, {8'hff, 1'b0, a, 1'b0});
	endtask
	always @(posedge clk_in) begin
		if (psel && penable && !pwrite && pready_out === 1'b1) begin
			exp_v = eq.pop_front();
			m_v = mq.pop_front();
			got_v = {pslverr_out, prdata_out[31:16], prdata_out[15:0] & m_v};
			n_checks++;
			if (got_v !== exp_v) begin
				n_mismatch++;
				$display("MISMATCH %0t read %h exp %h", $time, got_v, exp_v);
			end
		end
	end
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h0;
		pwdata <= 32'h0;
		port_en <= 1'b0;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(IDX_TX_CTRL, 16'h0800, 16'hffff);
		rd(IDX_RX_CTRL, 16'h0800, 16'hffff);
		rd(IDX_TX_LAT, 16'h0001, 16'hffff);
		rd(IDX_RX_LAT, 16'h0001, 16'h0007);
		rd(IDX_TX_STAT, 16'h0001, 16'hffff);
		rd(IDX_RX_FIFO, 16'h0080, 16'hffff);
		rd(IDX_RX_STAT, 16'h0008, 16'h0008);
		rd(IDX_RX_IE, 16'h0000, 16'hffff);
		apb(1'b0, 8'hca, 16'h0, {1'b1, 32'h0}, 16'hffff);
		repeat (20) pulse(1'b1);
		rd(IDX_RX_STAT, 16'h0009, 16'h000b);
		wr(IDX_TX_LAT, 16'h0001);
		wr(IDX_RX_LAT, 16'h0007);
		rd(IDX_TX_LAT, 16'h0000, 16'h0001);
		rd(IDX_RX_LAT, 16'h0000, 16'h0007);
		wr(IDX_TX_IE, 16'h0001);
		wr(IDX_RX_IE, 16'h0007);
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			c[i] = seed[5:0];
			wr(IDX_TX_CTRL, 16'h0000);
			wr(IDX_TX_VAL, {10'h0, c[i]});
			wr(IDX_TX_CTRL, 16'h0005);
			if (i == 0)
				frame(c[0]);
			rd(IDX_TX_STAT, 16'h0000, 16'h0001);
			repeat (180) pulse(1'b1);
			rd(IDX_TX_STAT, 16'h0001, 16'h0001);
		end
		rd(IDX_RX_LAT, 16'h0007, 16'h0007);
		chk({15'h0, irq_out}, 16'h0000);
		port_en <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk({15'h0, irq_out}, 16'h0001);
		for (int i = 0; i < 4; i++)
			rd(IDX_RX_FIFO, {10'h0, c[i]}, 16'h00bf);
		rd(IDX_RX_FIFO, 16'h0080, 16'h00bf);
		rd(IDX_RX_STAT, 16'h0008, 16'h0008);
		wr(IDX_RX_LAT, 16'h0007);
		wr(IDX_TX_LAT, 16'h0001);
		repeat (3) @(posedge clk_in);
		chk({15'h0, irq_out}, 16'h0000);
		seed = xs(seed);
		{x, y, z} = seed[17:0];
		wr(IDX_TX_CTRL, 16'h0000);
		wr(IDX_TX_VAL, {10'h0, x});
		wr(IDX_TX_CTRL, 16'h0007);
		frame(x);
		repeat (200) pulse(1'b1);
		rd(IDX_RX_STAT, 16'h0002, 16'h0003);
		rd(IDX_TX_STAT, 16'h0000, 16'h0001);
		wr(IDX_TX_CTRL, 16'h0000);
		wr(IDX_TX_VAL, {2'h0, z, 2'h0, y});
		wr(IDX_TX_CTRL, 16'h0006);
		frame(y);
		repeat (144) pulse(1'b1);
		frame(z);
		repeat (180) pulse(1'b1);
		rd(IDX_TX_STAT, 16'h0001, 16'h0001);
		wr(IDX_RX_CTRL, 16'h0001);
		rd(IDX_RX_FIFO, 16'h0080, 16'h00bf);
		rd(IDX_RX_STAT, 16'h0008, 16'h000a);
		wr(IDX_TX_CTRL, 16'h0000);
		wr(IDX_TX_CTRL, 16'h0007);
		repeat (40) pulse(1'b1);
		rd(IDX_RX_STAT, 16'h0008, 16'h000a);
		wr(IDX_RX_LAT, 16'h0007);
		wr(IDX_RX_CTRL, 16'h0000);
		repeat (60) pulse(1'b1);
		rd(IDX_RX_STAT, 16'h0002, 16'h000a);
		rd(IDX_RX_LAT, 16'h0002, 16'h0002);
		wr(IDX_TX_LAT, 16'h0001);
		wr(IDX_TX_CTRL, 16'h0000);
		wr(IDX_TX_CTRL, 16'h0004);
		rd(IDX_TX_STAT, 16'h0001, 16'h0001);
		rd(IDX_TX_LAT, 16'h0001, 16'h0001);
		repeat (20) pulse(1'b1);
		chk(last16, 16'hffff);
		stop_test();
	end
endmodule
`default_nettype wire
